//--- design/step_dir_pkg.sv
// constants, types and helpers shared by the step/direction motor interface
package step_dir_pkg;

  // clock and timing
  localparam int CLK_NS       = 8;
  localparam int MS_NS        = 1_000_000;
  localparam int CYC_PER_MS   = MS_NS / CLK_NS;
  localparam int WAKE_MS      = 500;
  localparam int HOLD_MS_RST  = 1000;

  // register offsets
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_RES       = 8'h04;
  localparam logic [7:0] REG_RUN_CUR   = 8'h08;
  localparam logic [7:0] REG_HOLD_CUR  = 8'h0C;
  localparam logic [7:0] REG_HOLD_MS   = 8'h10;
  localparam logic [7:0] REG_STATUS    = 8'h14;
  localparam logic [7:0] REG_POSITION  = 8'h18;
  localparam logic [7:0] REG_IRQ_STAT  = 8'h1C;
  localparam logic [7:0] REG_IRQ_MASK  = 8'h20;

  // fields
  localparam int CTRL_EDGE_BIT = 0;
  localparam int CTRL_MODE_LSB = 4;
  localparam int MODE_W        = 3;
  localparam int RES_W         = 4;
  localparam int CUR_W         = 7;
  localparam int HOLD_MS_W     = 16;
  localparam int PHASE_W       = 10;
  localparam int IRQ_W         = 4;
  localparam int IRQ_FAULT     = 0;
  localparam int IRQ_STALL     = 1;
  localparam int IRQ_INDEX     = 2;
  localparam int IRQ_HOLD      = 3;
  localparam int ST_ENABLED    = 0;
  localparam int ST_MOVING     = 1;
  localparam int ST_HOLDING    = 2;
  localparam int ST_DIR        = 3;
  localparam int ST_WAKING     = 4;

  // reset values and limits; currents in 0.05 A units
  localparam logic [RES_W-1:0] RES_RST      = 4'h0_00E;
  localparam logic [CUR_W-1:0] RUN_CUR_RST  = 7'h0_014;
  localparam logic [CUR_W-1:0] HOLD_CUR_RST = 7'h0_00A;
  localparam logic [CUR_W-1:0] RUN_CUR_MIN  = 7'h0_002;
  localparam logic [CUR_W-1:0] CUR_MAX      = 7'h0_064;
  localparam logic [RES_W-1:0] RES_LAST     = 4'h0_00E;

  typedef enum logic [MODE_W-1:0] {
    OUT_OFF, OUT_DIR, OUT_FAULT, OUT_INDEX, OUT_STALL, OUT_MOVING, OUT_HOLDING
  } out_mode_e;

  typedef enum logic [1:0] {DRV_WAKE, DRV_OFF, DRV_HOLD, DRV_RUN} drive_state_e;

  // microsteps per full step for each resolution code
  function automatic logic [8:0] resDivisor(input logic [RES_W-1:0] code);
    case (code)
      4'h0_000: resDivisor = 9'h0_001;
      4'h0_001: resDivisor = 9'h0_002;
      4'h0_002: resDivisor = 9'h0_004;
      4'h0_003: resDivisor = 9'h0_005;
      4'h0_004: resDivisor = 9'h0_008;
      4'h0_005: resDivisor = 9'h0_00A;
      4'h0_006: resDivisor = 9'h0_010;
      4'h0_007: resDivisor = 9'h0_019;
      4'h0_008: resDivisor = 9'h0_020;
      4'h0_009: resDivisor = 9'h0_032;
      4'h0_00A: resDivisor = 9'h0_040;
      4'h0_00B: resDivisor = 9'h0_07D;
      4'h0_00C: resDivisor = 9'h0_080;
      4'h0_00D: resDivisor = 9'h0_0FA;
      default:  resDivisor = 9'h0_100;
    endcase
  endfunction

  // clamp a requested current code into [lo, CUR_MAX]
  function automatic logic [CUR_W-1:0] clampCur(input logic [31:0] req, input logic [CUR_W-1:0] lo);
    if (req > 32'(CUR_MAX)) begin
      clampCur = CUR_MAX;
    end else if (req < 32'(lo)) begin
      clampCur = lo;
    end else begin
      clampCur = req[CUR_W-1:0];
    end
  endfunction

endpackage

//--- design/pin_sync_if.sv
// synchronised and edge-detected pin events between the pin stage and the core
`timescale 1ns/1ps
`default_nettype none
interface pin_sync_if;
  logic stepRise;
  logic stepFall;
  logic dirLvl;
  logic enLvl;
  logic indexRise;
  modport src (output stepRise, output stepFall, output dirLvl, output enLvl, output indexRise);
  modport dst (input stepRise, input stepFall, input dirLvl, input enLvl, input indexRise);
endinterface
`default_nettype wire

//--- design/pin_sync.sv
// two-stage synchronisers and edge detection for the isolated input pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic stepPin,
  input  wire logic dirPin,
  input  wire logic disablePin,
  input  wire logic indexPin,
  pin_sync_if.src   evt
);
  logic [3:0] meta_r;
  logic [3:0] sync_r;
  logic       stepLast_r;
  logic       indexLast_r;

  // first stage feeds only the second; pins idle high (pulled up)
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_r <= 4'h0_00F;
      sync_r <= 4'h0_00F;
    end else begin
      meta_r <= {indexPin, disablePin, dirPin, stepPin};
      sync_r <= meta_r;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stepLast_r  <= 1'b1;
      indexLast_r <= 1'b1;
    end else begin
      stepLast_r  <= sync_r[0];
      indexLast_r <= sync_r[3];
    end
  end

  // one-cycle step and index events, each edge seen once; dir and enable are levels
  assign evt.stepRise  = sync_r[0] & ~stepLast_r;
  assign evt.stepFall  = ~sync_r[0] & stepLast_r;
  assign evt.dirLvl    = sync_r[1];
  assign evt.enLvl     = sync_r[2];
  assign evt.indexRise = sync_r[3] & ~indexLast_r;
endmodule
`default_nettype wire

//--- design/step_dir_motor_interface.sv
// step/direction command core: microstep position, current setpoint, output pin, registers
`timescale 1ns/1ps
`default_nettype none
module step_dir_motor_interface #(
  parameter int CYC_PER_MS = step_dir_pkg::CYC_PER_MS,
  parameter int WAKE_MS    = step_dir_pkg::WAKE_MS
) (
  input  wire logic                              clk,
  input  wire logic                              sys_rst,
  input  wire logic                              stepPin,
  input  wire logic                              dirPin,
  input  wire logic                              disablePin,
  input  wire logic                              indexPin,
  input  wire logic                              faultIn,
  input  wire logic                              stallIn,
  input  wire logic [7:0]                        regAddr,
  input  wire logic [31:0]                       regWdata,
  input  wire logic                              regWr,
  input  wire logic                              regRd,
  output logic      [31:0]                       regRdata,
  output logic                                   driveEnable,
  output logic      [step_dir_pkg::CUR_W-1:0]    coilCurrent,
  output logic      [step_dir_pkg::PHASE_W-1:0]  phaseIdx,
  output logic                                   stepPulse,
  output logic                                   motorDir,
  output logic                                   outClosed,
  output logic                                   irq
);
  import step_dir_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // pin stage

  pin_sync_if evt ();

  pin_sync u_sync (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .stepPin    (stepPin),
    .dirPin     (dirPin),
    .disablePin (disablePin),
    .indexPin   (indexPin),
    .evt        (evt)
  );

  //////////////////////////////////////////////////////////////////////////////
  // configuration registers

  logic                  fallEdge_r;
  out_mode_e             outMode_r;
  logic [RES_W-1:0]      res_r;
  logic [CUR_W-1:0]      runCur_r;
  logic [CUR_W-1:0]      holdCur_r;
  logic [HOLD_MS_W-1:0]  holdMs_r;
  logic [IRQ_W-1:0]      irqMask_r;
  logic                  resWrite;

  assign resWrite = regWr && regAddr == REG_RES && regWdata[RES_W-1:0] <= RES_LAST;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fallEdge_r <= 1'b0;
      outMode_r  <= OUT_OFF;
      res_r      <= RES_RST;
      runCur_r   <= RUN_CUR_RST;
      holdCur_r  <= HOLD_CUR_RST;
      holdMs_r   <= HOLD_MS_W'(HOLD_MS_RST);
      irqMask_r  <= '0;
    end else if (regWr) begin
      if (regAddr == REG_CTRL) begin
        fallEdge_r <= regWdata[CTRL_EDGE_BIT];
        // unused mode codes park the output open
        if (regWdata[CTRL_MODE_LSB +: MODE_W] > MODE_W'(OUT_HOLDING)) begin
          outMode_r <= OUT_OFF;
        end else begin
          outMode_r <= out_mode_e'(regWdata[CTRL_MODE_LSB +: MODE_W]);
        end
      end else if (resWrite) begin
        res_r <= regWdata[RES_W-1:0];
      end else if (regAddr == REG_RUN_CUR) begin
        runCur_r <= clampCur(regWdata, RUN_CUR_MIN);
      end else if (regAddr == REG_HOLD_CUR) begin
        holdCur_r <= clampCur(regWdata, '0);
      end else if (regAddr == REG_HOLD_MS) begin
        holdMs_r <= regWdata[HOLD_MS_W-1:0];
      end else if (regAddr == REG_IRQ_MASK) begin
        irqMask_r <= regWdata[IRQ_W-1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // millisecond tick and wake-up after power-down

  logic [$clog2(CYC_PER_MS)-1:0] msDiv_r;
  logic                          msTick;
  logic [$clog2(WAKE_MS+1)-1:0]  wakeMs_r;
  logic                          awake;

  assign msTick = msDiv_r == ($clog2(CYC_PER_MS))'(CYC_PER_MS - 1);
  assign awake  = wakeMs_r == ($clog2(WAKE_MS+1))'(WAKE_MS);

  always_ff @(posedge clk) begin
    if (sys_rst || msTick) begin
      msDiv_r <= '0;
    end else begin
      msDiv_r <= msDiv_r + 1'b1;
    end
  end

  // drive stays off until the wake interval has run out
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wakeMs_r <= '0;
    end else if (msTick && !awake) begin
      wakeMs_r <= wakeMs_r + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // step acceptance and position

  drive_state_e         state_r;
  logic                 enabled;
  logic                 stepAcc;
  logic [9:0]           phaseMod;
  logic [31:0]          position_r;
  logic                 lastDir_r;

  // steps count only while the drive is actually on, so none lands in the off-to-hold cycle
  assign enabled  = evt.enLvl && (state_r == DRV_HOLD || state_r == DRV_RUN);
  // steps while disabled or waking are dropped, not queued
  assign stepAcc  = enabled && (fallEdge_r ? evt.stepFall : evt.stepRise);
  assign phaseMod = 10'({resDivisor(res_r), 2'b00});

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phaseIdx   <= '0;
      position_r <= '0;
      lastDir_r  <= 1'b1;
      motorDir   <= 1'b1;
      stepPulse  <= 1'b0;
    end else begin
      stepPulse <= stepAcc;
      if (stepAcc) begin
        lastDir_r <= evt.dirLvl;
        motorDir  <= evt.dirLvl;
        if (evt.dirLvl) begin
          position_r <= position_r + 1'b1;
          phaseIdx   <= (phaseIdx == phaseMod - 1'b1) ? '0 : phaseIdx + 1'b1;
        end else begin
          position_r <= position_r - 1'b1;
          phaseIdx   <= (phaseIdx == '0) ? phaseMod - 1'b1 : phaseIdx - 1'b1;
        end
      end
      if (resWrite) begin
        phaseIdx <= '0; // full-step restart on a scale change; a step in that cycle still counts
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // run/hold state

  logic [HOLD_MS_W-1:0] idleMs_r;
  logic                 holdEntered;

  always_ff @(posedge clk) begin
    if (sys_rst || stepAcc) begin
      idleMs_r <= '0;
    end else if (msTick && idleMs_r != holdMs_r) begin
      idleMs_r <= idleMs_r + 1'b1;
    end
  end

  assign holdEntered = state_r == DRV_RUN && !stepAcc && idleMs_r >= holdMs_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= DRV_WAKE;
    end else begin
      case (state_r)
        DRV_WAKE: begin
          if (awake) begin
            state_r <= DRV_OFF;
          end
        end
        DRV_OFF: begin
          if (evt.enLvl) begin
            state_r <= DRV_HOLD;
          end
        end
        DRV_HOLD: begin
          if (!evt.enLvl) begin
            state_r <= DRV_OFF;
          end else if (stepAcc) begin
            state_r <= DRV_RUN;
          end
        end
        DRV_RUN: begin
          if (!evt.enLvl) begin
            state_r <= DRV_OFF;
          end else if (holdEntered) begin
            state_r <= DRV_HOLD;
          end
        end
        default: state_r <= DRV_OFF;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      driveEnable <= 1'b0;
      coilCurrent <= '0;
    end else begin
      driveEnable <= state_r == DRV_HOLD || state_r == DRV_RUN;
      if (state_r == DRV_RUN) begin
        coilCurrent <= runCur_r;
      end else if (state_r == DRV_HOLD) begin
        coilCurrent <= holdCur_r;
      end else begin
        coilCurrent <= '0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // digital output

  logic indexTgl_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      indexTgl_r <= 1'b0;
    end else if (evt.indexRise) begin
      indexTgl_r <= ~indexTgl_r;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      outClosed <= 1'b0;
    end else begin
      case (outMode_r)
        OUT_DIR:     outClosed <= lastDir_r;
        OUT_FAULT:   outClosed <= faultIn;
        OUT_INDEX:   outClosed <= indexTgl_r;
        OUT_STALL:   outClosed <= stallIn;
        OUT_MOVING:  outClosed <= state_r == DRV_RUN;
        OUT_HOLDING: outClosed <= state_r == DRV_HOLD;
        default:     outClosed <= 1'b0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky, write one to clear, a new event wins over the clear

  logic [IRQ_W-1:0] irqStat_r;
  logic [IRQ_W-1:0] irqSet;
  logic [IRQ_W-1:0] irqClr;
  logic             faultLast_r;
  logic             stallLast_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      faultLast_r <= 1'b0;
      stallLast_r <= 1'b0;
    end else begin
      faultLast_r <= faultIn;
      stallLast_r <= stallIn;
    end
  end

  always_comb begin
    irqSet            = '0;
    irqSet[IRQ_FAULT] = faultIn & ~faultLast_r;
    irqSet[IRQ_STALL] = stallIn & ~stallLast_r;
    irqSet[IRQ_INDEX] = evt.indexRise;
    irqSet[IRQ_HOLD]  = holdEntered;
    irqClr            = (regWr && regAddr == REG_IRQ_STAT) ? regWdata[IRQ_W-1:0] : '0;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqStat_r <= '0;
      irq       <= 1'b0;
    end else begin
      irqStat_r <= (irqStat_r & ~irqClr) | irqSet;
      irq       <= |(((irqStat_r & ~irqClr) | irqSet) & irqMask_r);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read port: data valid only in the cycle after the strobe

  logic [31:0] statusWord;

  always_comb begin
    statusWord              = '0;
    statusWord[ST_ENABLED]  = driveEnable;
    statusWord[ST_MOVING]   = state_r == DRV_RUN;
    statusWord[ST_HOLDING]  = state_r == DRV_HOLD;
    statusWord[ST_DIR]      = lastDir_r;
    statusWord[ST_WAKING]   = state_r == DRV_WAKE;
  end

  always_ff @(posedge clk) begin
    if (sys_rst || !regRd) begin
      regRdata <= '0;
    end else if (regAddr == REG_CTRL) begin
      regRdata <= 32'({outMode_r, 3'b000, fallEdge_r});
    end else if (regAddr == REG_RES) begin
      regRdata <= 32'(res_r);
    end else if (regAddr == REG_RUN_CUR) begin
      regRdata <= 32'(runCur_r);
    end else if (regAddr == REG_HOLD_CUR) begin
      regRdata <= 32'(holdCur_r);
    end else if (regAddr == REG_HOLD_MS) begin
      regRdata <= 32'(holdMs_r);
    end else if (regAddr == REG_STATUS) begin
      regRdata <= statusWord;
    end else if (regAddr == REG_POSITION) begin
      regRdata <= position_r;
    end else if (regAddr == REG_IRQ_STAT) begin
      regRdata <= 32'(irqStat_r);
    end else if (regAddr == REG_IRQ_MASK) begin
      regRdata <= 32'(irqMask_r);
    end else begin
      regRdata <= '0;
    end
  end

endmodule
`default_nettype wire

//--- bench/step_dir_asserts.sv
// port-level checks on the step/direction core
`timescale 1ns/1ps
`default_nettype none
module step_dir_asserts
  import step_dir_pkg::*;
(
  input wire logic                            clk,
  input wire logic                            sys_rst,
  input wire logic                            dirPin,
  input wire logic                            disablePin,
  input wire logic                            regWr,
  input wire logic                            driveEnable,
  input wire logic [step_dir_pkg::CUR_W-1:0]   coilCurrent,
  input wire logic [step_dir_pkg::PHASE_W-1:0] phaseIdx,
  input wire logic                            stepPulse,
  input wire logic                            motorDir
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  //////////////////////////////////////////////////
  AST_STEP_ONE: assert property (stepPulse |=> !stepPulse)
    else $error("step pulse wider than one cycle");
  AST_STEP_PHASE: assert property (stepPulse |-> phaseIdx != $past(phaseIdx))
    else $error("phase did not advance on a step");
  AST_PHASE_HOLD: assert property (!stepPulse && !$past(regWr) && !$past(regWr, 2) |-> $stable(phaseIdx))
    else $error("phase moved without a step");
  AST_DIR_HOLD: assert property (!stepPulse |-> $stable(motorDir))
    else $error("direction changed without a step");
  // dir is held well around each edge, so four cycles back is inside that window
  AST_DIR_SAMPLE: assert property (stepPulse |-> motorDir == $past(dirPin, 4))
    else $error("step direction differs from the pin");
  AST_DIS_OFF: assert property (!disablePin [*6] |-> !driveEnable)
    else $error("drive on while disable pin low");
  AST_OFF_ZERO: assert property (!driveEnable |-> coilCurrent == '0)
    else $error("current with drive off");
  AST_STEP_EN: assert property (stepPulse |-> driveEnable)
    else $error("step taken while drive off");
  AST_CUR_RANGE: assert property (coilCurrent <= CUR_MAX)
    else $error("current code above maximum");
endmodule
bind step_dir_motor_interface step_dir_asserts chk_u (.clk(clk), .sys_rst(sys_rst), .dirPin(dirPin),
  .disablePin(disablePin), .regWr(regWr), .driveEnable(driveEnable), .coilCurrent(coilCurrent),
  .phaseIdx(phaseIdx), .stepPulse(stepPulse), .motorDir(motorDir));
`default_nettype wire

//--- bench/step_pulse_gen.sv
// behavioural step/direction pulse source
`timescale 1ns/1ps
`default_nettype none
module step_pulse_gen #(
  parameter int LOW_CYC = 25
) (
  input  wire logic clk,
  input  wire logic go,
  input  wire logic dirReq,
  output var  logic stepPin,
  output var  logic dirPin
);
  initial begin
    stepPin = 1'b1;
    dirPin  = 1'b1;
  end
  // dir set 6 cycles ahead and held 8 after; low phase of 200 ns minimum
  always @(posedge clk) begin
    if (go) begin
      dirPin <= dirReq;
      repeat (6) @(posedge clk);
      stepPin <= 1'b0;
      repeat (LOW_CYC) @(posedge clk);
      stepPin <= 1'b1;
      repeat (8) @(posedge clk);
    end
  end
endmodule
`default_nettype wire

//--- bench/tb_top.sv
// self-checking bench for the step/direction core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import step_dir_pkg::*;
  localparam int CYC  = 10;
  localparam int WAKE = 2;
  logic        clk, sys_rst, go, dirReq, stepPin, dirPin, disablePin, indexPin, faultIn, stallIn;
  logic [7:0]  regAddr;
  logic [31:0] regWdata, regRdata, v;
  logic        regWr, regRd, driveEnable, stepPulse, motorDir, outClosed, irq;
  logic [CUR_W-1:0]   coilCurrent;
  logic [PHASE_W-1:0] phaseIdx;
  int          errorCnt, comparisons, pos;
  step_pulse_gen gen_u (.clk(clk), .go(go), .dirReq(dirReq), .stepPin(stepPin), .dirPin(dirPin));
  step_dir_motor_interface #(.CYC_PER_MS(CYC), .WAKE_MS(WAKE)) dut_u (.clk(clk), .sys_rst(sys_rst),
    .stepPin(stepPin), .dirPin(dirPin), .disablePin(disablePin), .indexPin(indexPin), .faultIn(faultIn),
    .stallIn(stallIn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .driveEnable(driveEnable), .coilCurrent(coilCurrent), .phaseIdx(phaseIdx),
    .stepPulse(stepPulse), .motorDir(motorDir), .outClosed(outClosed), .irq(irq));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  //////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      errorCnt++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    d = regRdata;
    @(posedge clk);
  endtask
  task automatic launch(input logic d);
    @(posedge clk);
    go     <= 1'b1;
    dirReq <= d;
    @(posedge clk);
    go <= 1'b0;
  endtask
  task automatic pulse(input logic d);
    launch(d);
    repeat (42) @(posedge clk);
  endtask
  task automatic setMode(input int m);
    wr(REG_CTRL, 32'(m) << CTRL_MODE_LSB);
    repeat (3) @(posedge clk);
  endtask
  task automatic tallyAndFinish();
    $display("comparisons %0d mismatches %0d", comparisons, errorCnt);
    if (errorCnt == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////
  task automatic testReset();
    chk("driveEnable", 1'b0, driveEnable);
    rd(REG_RES, v);     chk("res", 32'h0000_000E, v);
    rd(REG_HOLD_MS, v); chk("holdMs", 32'h0000_03E8, v);
    rd(REG_STATUS, v);  chk("waking", 1'b1, v[ST_WAKING]);
    rd(8'h3C, v);       chk("unmapped", 32'h0000_0000, v);
    for (int i = 0; i < WAKE * CYC + 10 && driveEnable !== 1'b1; i++) @(posedge clk);
    chk("driveEnable", 1'b1, driveEnable);
    chk("coilHold", 32'h0000_000A, 32'(coilCurrent));
    $display("reset test done");
  endtask
  task automatic testCurrent();
    wr(REG_RUN_CUR, 32'h0000_0001);  rd(REG_RUN_CUR, v);  chk("runMin", 32'h0000_0002, v);
    wr(REG_RUN_CUR, 32'h0000_00C8);  rd(REG_RUN_CUR, v);  chk("runMax", 32'h0000_0064, v);
    wr(REG_HOLD_CUR, 32'h0000_0000); rd(REG_HOLD_CUR, v); chk("holdZero", 32'h0000_0000, v);
    wr(REG_RUN_CUR, 32'h0000_001E);
    wr(REG_HOLD_CUR, 32'h0000_0004);
    $display("current test done");
  endtask
  task automatic testSteps();
    wr(REG_HOLD_MS, 32'h0000_0006);
    // 44 cycles between steps, hold needs 50..60 idle cycles
    for (int i = 0; i < 3; i++) begin
      pulse(1'b1);
      chk("coilRun", 32'h0000_001E, 32'(coilCurrent));
    end
    chk("motorDir", 1'b1, motorDir);
    repeat (70) @(posedge clk);
    chk("coilHold", 32'h0000_0004, 32'(coilCurrent));
    pulse(1'b0);
    pulse(1'b0);
    pos = 1;
    chk("motorDir", 1'b0, motorDir);
    rd(REG_POSITION, v); chk("position", 32'(pos), v);
    $display("step test done");
  endtask
  task automatic testRes();
    for (int c = 0; c < 15; c++) begin
      wr(REG_RES, 32'(c)); rd(REG_RES, v); chk("resCode", 32'(c), v);
    end
    wr(REG_RES, 32'h0000_000F); rd(REG_RES, v); chk("resBad", 32'h0000_000E, v);
    wr(REG_RES, 32'h0000_0000);
    pulse(1'b1);
    chk("phaseFull", 32'h0000_0001, 32'(phaseIdx));
    for (int i = 0; i < 3; i++) pulse(1'b1);
    chk("phaseWrap", 32'h0000_0000, 32'(phaseIdx));
    pos += 4;
    $display("resolution test done");
  endtask
  task automatic testEdge();
    wr(REG_CTRL, 32'h0000_0001);
    launch(1'b1);
    repeat (10) @(posedge clk);
    rd(REG_POSITION, v); chk("fallStep", 32'(pos + 1), v);
    repeat (32) @(posedge clk);
    pos += 1;
    rd(REG_POSITION, v); chk("fallOnce", 32'(pos), v);
    wr(REG_CTRL, 32'h0000_0000);
    launch(1'b1);
    repeat (10) @(posedge clk);
    rd(REG_POSITION, v); chk("riseWait", 32'(pos), v);
    repeat (32) @(posedge clk);
    pos += 1;
    rd(REG_POSITION, v); chk("riseStep", 32'(pos), v);
    $display("edge test done");
  endtask
  task automatic testDisable();
    disablePin <= 1'b0;
    repeat (6) @(posedge clk);
    chk("driveOff", 1'b0, driveEnable);
    pulse(1'b1);
    rd(REG_POSITION, v); chk("noStep", 32'(pos), v);
    disablePin <= 1'b1;
    for (int i = 0; i < 10 && driveEnable !== 1'b1; i++) @(posedge clk);
    chk("driveOn", 1'b1, driveEnable);
    $display("disable test done");
  endtask
  task automatic testOutput();
    logic prev;
    setMode(7); rd(REG_CTRL, v); chk("modeBad", 32'h0000_0000, v);
    chk("outBad", 1'b0, outClosed);
    setMode(0); chk("outOff", 1'b0, outClosed);
    setMode(1); chk("outDirCcw", 1'b1, outClosed);
    pulse(1'b0); chk("outDirCw", 1'b0, outClosed);
    repeat (70) @(posedge clk);
    setMode(6); chk("outHolding", 1'b1, outClosed);
    setMode(5); chk("outMoving", 1'b0, outClosed);
    setMode(4); stallIn <= 1'b1; repeat (3) @(posedge clk);
    chk("outStall", 1'b1, outClosed);
    stallIn <= 1'b0;
    setMode(3); prev = outClosed;
    indexPin <= 1'b1; repeat (4) @(posedge clk); indexPin <= 1'b0; repeat (6) @(posedge clk);
    chk("outIndex", !prev, outClosed);
    setMode(2);
    wr(REG_IRQ_STAT, 32'h0000_000F);
    wr(REG_IRQ_MASK, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk("irqIdle", 1'b0, irq);
    faultIn <= 1'b1; repeat (3) @(posedge clk);
    chk("outFault", 1'b1, outClosed);
    chk("irqFault", 1'b1, irq);
    faultIn <= 1'b0;
    stallIn <= 1'b1; repeat (3) @(posedge clk); stallIn <= 1'b0;
    wr(REG_IRQ_STAT, 32'h0000_0001);
    rd(REG_IRQ_STAT, v); chk("irqStat", 32'h0000_0002, v & 32'h0000_0003);
    chk("irqMasked", 1'b0, irq);
    $display("output test done");
  endtask
  //////////////////////////////////////////////////
  initial begin
    errorCnt = 0; comparisons = 0; pos = 0;
    sys_rst = 1'b1; go = 1'b0; dirReq = 1'b1; disablePin = 1'b1; indexPin = 1'b0;
    faultIn = 1'b0; stallIn = 1'b0; regAddr = 8'h00; regWdata = '0; regWr = 1'b0; regRd = 1'b0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    testReset();
    testCurrent();
    testSteps();
    testRes();
    testEdge();
    testDisable();
    testOutput();
    tallyAndFinish();
  end
  // whole run is about 1000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    errorCnt++;
    tallyAndFinish();
  end
endmodule
`default_nettype wire
